// *** logic/decoder_pkg.sv ***
package decoder_pkg;

	// Word and field widths
	localparam int INSTR_W     = 14;
	localparam int FILE_ADDR_W = 7;
	localparam int LIT_W       = 8;
	localparam int JUMP_W      = 11;

	// Field positions inside the instruction word
	localparam int TOP_HI   = 13;
	localparam int TOP_LO   = 12;
	localparam int FN_HI    = 11;
	localparam int FN_LO    = 8;
	localparam int DEST_BIT = 7;
	localparam int FILE_HI  = 6;
	localparam int BITOP_HI = 11;
	localparam int BITOP_LO = 10;
	localparam int BIDX_HI  = 9;
	localparam int BIDX_LO  = 7;
	localparam int JMP_SEL  = 11;
	localparam int LFN_HI   = 11;
	localparam int LFN_LO   = 8;
	localparam int LOW_HI   = 7;
	localparam int NOP_X_LO = 4;

	// Instruction classes in the top two bits
	localparam logic [1:0] TOP_BYTE = 2'h0;
	localparam logic [1:0] TOP_BIT  = 2'h1;
	localparam logic [1:0] TOP_JUMP = 2'h2;
	localparam logic [1:0] TOP_LIT  = 2'h3;

	// Byte-oriented function codes
	localparam logic [3:0] FN_MISC  = 4'h0;
	localparam logic [3:0] FN_CLEAR = 4'h1;
	localparam logic [3:0] FN_SUB   = 4'h2;
	localparam logic [3:0] FN_DEC   = 4'h3;
	localparam logic [3:0] FN_OR    = 4'h4;
	localparam logic [3:0] FN_AND   = 4'h5;
	localparam logic [3:0] FN_XOR   = 4'h6;
	localparam logic [3:0] FN_ADD   = 4'h7;
	localparam logic [3:0] FN_MOVE  = 4'h8;
	localparam logic [3:0] FN_COMP  = 4'h9;
	localparam logic [3:0] FN_INC   = 4'ha;
	localparam logic [3:0] FN_DECSK = 4'hb;
	localparam logic [3:0] FN_ROTR  = 4'hc;
	localparam logic [3:0] FN_ROTL  = 4'hd;
	localparam logic [3:0] FN_SWAP  = 4'he;
	localparam logic [3:0] FN_INCSK = 4'hf;

	// Bit-oriented operation codes
	localparam logic [1:0] BOP_CLEAR = 2'h0;
	localparam logic [1:0] BOP_SET   = 2'h1;
	localparam logic [1:0] BOP_TCLR  = 2'h2;
	localparam logic [1:0] BOP_TSET  = 2'h3;

	// Literal function codes (upper bits or the whole of the four-bit field)
	localparam logic [1:0] LIT_MOVE_HI = 2'h0;
	localparam logic [1:0] LIT_RET_HI  = 2'h1;
	localparam logic [3:0] LIT_OR      = 4'h8;
	localparam logic [3:0] LIT_AND     = 4'h9;
	localparam logic [3:0] LIT_XOR     = 4'ha;
	localparam logic [2:0] LIT_SUB_HI  = 3'h6;
	localparam logic [2:0] LIT_ADD_HI  = 3'h7;

	// Fixed low bytes of the control words
	localparam logic [7:0] LOW_RET_SUB  = 8'h08;
	localparam logic [7:0] LOW_RET_INT  = 8'h09;
	localparam logic [7:0] LOW_WDT_CLR  = 8'h64;
	localparam logic [7:0] LOW_STANDBY  = 8'h63;

	// Source values whose step result is zero
	localparam logic [7:0] DEC_ZERO_SRC = 8'h01;
	localparam logic [7:0] INC_ZERO_SRC = 8'hff;

	// Instruction cycle timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_PER_INSTR = 4;

	typedef enum logic [5:0] {
		op_nop, op_move_w_to_f, op_clear, op_sub_f, op_dec_f, op_or_f, op_and_f,
		op_xor_f, op_add_f, op_move_f, op_comp_f, op_inc_f, op_dec_skip,
		op_rot_right, op_rot_left, op_swap_f, op_inc_skip, op_bit_clear,
		op_bit_set, op_test_clear, op_test_set, op_call, op_jump, op_move_lit,
		op_ret_lit, op_or_lit, op_and_lit, op_xor_lit, op_sub_lit, op_add_lit,
		op_ret_sub, op_ret_int, op_wdt_clear, op_standby
	} op_t;

	typedef enum {cycle_first, cycle_second} cycle_t;

	typedef struct packed {
		logic carry;
		logic digit_carry_flag;
		logic zero;
		logic timeout_flag;
		logic powerdown_flag;
	} flags_t;

	typedef struct packed {
		op_t                    op;
		logic [FILE_ADDR_W-1:0] file_addr;
		logic                   dest_file;
		logic [2:0]             bit_index;
		logic [LIT_W-1:0]       literal;
		logic [JUMP_W-1:0]      jump_addr;
		flags_t                 flags;
		logic                   uses_file;
		logic                   writes_file;
		logic                   writes_w;
		logic                   two_cycle;
		logic                   conditional;
	} decode_t;

	localparam decode_t DECODE_RESET = '0;

endpackage : decoder_pkg

// *** logic/instr_decoder.sv ***
module instr_decoder
	import decoder_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [INSTR_W-1:0]     instr_word,
	input  wire logic [LIT_W-1:0]       file_data,
	input  wire logic [FILE_ADDR_W-1:0] first_io_port_addr,
	input  wire logic [FILE_ADDR_W-1:0] timer_zero_count_addr,
	input  wire logic                   prescaler_on_timer,
	output decode_t                     decoded,
	output logic [1:0]                  phase,
	output logic                        cycle_start,
	output logic                        second_cycle,
	output logic                        skip_next,
	output logic                        read_pins,
	output logic                        clear_prescaler
);

	decode_t    next_decode;
	cycle_t     cycle;
	logic [1:0] div_phase;
	logic       div_start;
	logic       div_finish;
	logic       dest;
	logic [3:0] fn;
	logic [7:0] low;
	logic       test_bit;
	logic       cond_true;

	// Instruction cycle of four oscillator periods
	phase_divider #(
		.PERIODS (OSC_PER_INSTR)
	) u_div (
		.clk    (clk),
		.rst    (rst),
		.phase  (div_phase),
		.start  (div_start),
		.finish (div_finish)
	);

	// Raw fields of the fetched word
	assign dest = instr_word[DEST_BIT];
	assign fn   = instr_word[FN_HI:FN_LO];
	assign low  = instr_word[LOW_HI:0];

	// Word to operation decode; table order follows the class bits
	always_comb begin
		next_decode           = DECODE_RESET;
		next_decode.file_addr = instr_word[FILE_HI:0];
		next_decode.bit_index = instr_word[BIDX_HI:BIDX_LO];
		next_decode.literal   = instr_word[LIT_W-1:0];
		next_decode.jump_addr = instr_word[JUMP_W-1:0];
		case (instr_word[TOP_HI:TOP_LO])
			TOP_BYTE: begin
				next_decode.uses_file   = 1'b1;
				next_decode.dest_file   = dest;
				next_decode.writes_file = dest;
				next_decode.writes_w    = ~dest;
				case (fn)
					FN_MISC: begin
						if (dest) begin
							next_decode.op       = op_move_w_to_f;
							next_decode.writes_w = 1'b0;
						end else begin
							next_decode.uses_file = 1'b0;
							next_decode.writes_w  = 1'b0;
							if (low == LOW_RET_SUB) begin
								next_decode.op        = op_ret_sub;
								next_decode.two_cycle = 1'b1;
							end else if (low == LOW_RET_INT) begin
								next_decode.op        = op_ret_int;
								next_decode.two_cycle = 1'b1;
							end else if (low == LOW_WDT_CLR) begin
								next_decode.op                   = op_wdt_clear;
								next_decode.flags.timeout_flag   = 1'b1;
								next_decode.flags.powerdown_flag = 1'b1;
							end else if (low == LOW_STANDBY) begin
								next_decode.op                   = op_standby;
								next_decode.flags.timeout_flag   = 1'b1;
								next_decode.flags.powerdown_flag = 1'b1;
							end else if (instr_word[NOP_X_LO-1:0] == 4'h0
								&& instr_word[NOP_X_LO] == 1'b0) begin
								// Bits 6 and 5 are left unexamined
								next_decode.op = op_nop;
							end else begin
								next_decode.op = op_nop;
							end
						end
					end
					FN_CLEAR: begin
						// Clear-working form ignores its low bits entirely
						next_decode.op         = op_clear;
						next_decode.flags.zero = 1'b1;
						next_decode.uses_file  = dest;
						if (!dest) begin
							next_decode.file_addr = '0;
						end
					end
					FN_SUB: begin
						next_decode.op = op_sub_f;
						next_decode.flags.carry            = 1'b1;
						next_decode.flags.digit_carry_flag = 1'b1;
						next_decode.flags.zero             = 1'b1;
					end
					FN_ADD: begin
						next_decode.op = op_add_f;
						next_decode.flags.carry            = 1'b1;
						next_decode.flags.digit_carry_flag = 1'b1;
						next_decode.flags.zero             = 1'b1;
					end
					FN_OR: begin
						next_decode.op         = op_or_f;
						next_decode.flags.zero = 1'b1;
					end
					FN_AND: begin
						next_decode.op         = op_and_f;
						next_decode.flags.zero = 1'b1;
					end
					FN_XOR: begin
						next_decode.op         = op_xor_f;
						next_decode.flags.zero = 1'b1;
					end
					FN_DEC: begin
						next_decode.op         = op_dec_f;
						next_decode.flags.zero = 1'b1;
					end
					FN_MOVE: begin
						next_decode.op         = op_move_f;
						next_decode.flags.zero = 1'b1;
					end
					FN_COMP: begin
						next_decode.op         = op_comp_f;
						next_decode.flags.zero = 1'b1;
					end
					FN_INC: begin
						next_decode.op         = op_inc_f;
						next_decode.flags.zero = 1'b1;
					end
					FN_DECSK: begin
						next_decode.op          = op_dec_skip;
						next_decode.conditional = 1'b1;
					end
					FN_INCSK: begin
						next_decode.op          = op_inc_skip;
						next_decode.conditional = 1'b1;
					end
					FN_ROTR: begin
						next_decode.op          = op_rot_right;
						next_decode.flags.carry = 1'b1;
					end
					FN_ROTL: begin
						next_decode.op          = op_rot_left;
						next_decode.flags.carry = 1'b1;
					end
					default: begin
						next_decode.op = op_swap_f;
					end
				endcase
			end
			TOP_BIT: begin
				next_decode.uses_file = 1'b1;
				next_decode.dest_file = 1'b1;
				case (instr_word[BITOP_HI:BITOP_LO])
					BOP_CLEAR: begin
						next_decode.op          = op_bit_clear;
						next_decode.writes_file = 1'b1;
					end
					BOP_SET: begin
						next_decode.op          = op_bit_set;
						next_decode.writes_file = 1'b1;
					end
					BOP_TCLR: begin
						next_decode.op          = op_test_clear;
						next_decode.conditional = 1'b1;
					end
					default: begin
						next_decode.op          = op_test_set;
						next_decode.conditional = 1'b1;
					end
				endcase
			end
			TOP_JUMP: begin
				next_decode.two_cycle = 1'b1;
				if (instr_word[JMP_SEL]) begin
					next_decode.op = op_jump;
				end else begin
					next_decode.op = op_call;
				end
			end
			default: begin
				next_decode.writes_w = 1'b1;
				if (instr_word[LFN_HI:LFN_HI-1] == LIT_MOVE_HI) begin
					next_decode.op = op_move_lit;
				end else if (instr_word[LFN_HI:LFN_HI-1] == LIT_RET_HI) begin
					next_decode.op        = op_ret_lit;
					next_decode.two_cycle = 1'b1;
				end else if (instr_word[LFN_HI:LFN_HI-2] == LIT_ADD_HI) begin
					next_decode.op = op_add_lit;
					next_decode.flags.carry            = 1'b1;
					next_decode.flags.digit_carry_flag = 1'b1;
					next_decode.flags.zero             = 1'b1;
				end else if (instr_word[LFN_HI:LFN_HI-2] == LIT_SUB_HI) begin
					next_decode.op = op_sub_lit;
					next_decode.flags.carry            = 1'b1;
					next_decode.flags.digit_carry_flag = 1'b1;
					next_decode.flags.zero             = 1'b1;
				end else if (instr_word[LFN_HI:LFN_LO] == LIT_XOR) begin
					next_decode.op         = op_xor_lit;
					next_decode.flags.zero = 1'b1;
				end else if (instr_word[LFN_HI:LFN_LO] == LIT_AND) begin
					next_decode.op         = op_and_lit;
					next_decode.flags.zero = 1'b1;
				end else if (instr_word[LFN_HI:LFN_LO] == LIT_OR) begin
					next_decode.op         = op_or_lit;
					next_decode.flags.zero = 1'b1;
				end else begin
					// Leftover literal code must not touch the working register
					next_decode.op       = op_nop;
					next_decode.writes_w = 1'b0;
				end
			end
		endcase
	end

	// Skip condition, judged on the operand read during this cycle
	assign test_bit = file_data[decoded.bit_index];
	always_comb begin
		cond_true = 1'b0;
		case (decoded.op)
			op_dec_skip: cond_true = (file_data == DEC_ZERO_SRC);
			op_inc_skip: cond_true = (file_data == INC_ZERO_SRC);
			op_test_clear: cond_true = ~test_bit;
			op_test_set: cond_true = test_bit;
			default: cond_true = 1'b0;
		endcase
	end

	// Decoded word latched at each cycle start; a second cycle shows idle
	always_ff @(posedge clk) begin
		if (rst) begin
			decoded <= DECODE_RESET;
		end else if (div_start) begin
			if (cycle == cycle_second) begin
				decoded <= DECODE_RESET;
			end else begin
				decoded <= next_decode;
			end
		end
	end

	// Cycle state: decided at the last phase, so the datapath has read the operand
	always_ff @(posedge clk) begin
		if (rst) begin
			cycle <= cycle_first;
		end else if (div_finish) begin
			if (cycle == cycle_first
				&& (decoded.two_cycle || (decoded.conditional && cond_true))) begin
				cycle <= cycle_second;
			end else begin
				cycle <= cycle_first;
			end
		end
	end

	// Skip pulse tells fetch to discard the prefetched word
	always_ff @(posedge clk) begin
		if (rst) begin
			skip_next <= 1'b0;
		end else begin
			skip_next <= div_finish && cycle == cycle_first
				&& decoded.conditional && cond_true;
		end
	end

	// Pin levels, not latch, feed a port that modifies itself
	always_ff @(posedge clk) begin
		if (rst) begin
			read_pins <= 1'b0;
		end else if (div_start) begin
			read_pins <= cycle == cycle_first && next_decode.uses_file
				&& next_decode.writes_file
				&& next_decode.file_addr == first_io_port_addr;
		end
	end

	// Prescaler clear pulses once, at the end of the writing cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			clear_prescaler <= 1'b0;
		end else begin
			clear_prescaler <= div_finish && decoded.writes_file && prescaler_on_timer
				&& decoded.file_addr == timer_zero_count_addr;
		end
	end

	// Timing outputs copied from the divider and cycle state
	always_ff @(posedge clk) begin
		if (rst) begin
			phase        <= 2'h0;
			cycle_start  <= 1'b0;
			second_cycle <= 1'b0;
		end else begin
			phase        <= div_phase;
			cycle_start  <= div_start;
			second_cycle <= (cycle == cycle_second);
		end
	end

endmodule : instr_decoder

// *** logic/phase_divider.sv ***
// Counts oscillator periods into instruction-cycle phases
module phase_divider
	import decoder_pkg::*;
#(
	parameter int PERIODS = OSC_PER_INSTR
) (
	input  wire logic       clk,
	input  wire logic       rst,
	output logic      [1:0] phase,
	output logic            start,
	output logic            finish
);

	localparam logic [1:0] LAST = 2'(PERIODS - 1);

	// Phase counter wraps once per instruction cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			phase <= 2'h0;
		end else if (phase == LAST) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// Enables are decoded one phase early, so they stay registered and line up with the phase they mark
	always_ff @(posedge clk) begin
		if (rst) begin
			start  <= 1'b0;
			finish <= 1'b0;
		end else begin
			start  <= (phase == LAST);
			finish <= (phase == LAST - 2'h1);
		end
	end

endmodule : phase_divider

// *** verif/decoder_checker.sv ***
module decoder_checker
	import decoder_pkg::*;
(
	input wire logic [INSTR_W-1:0]     instr_word,
	input wire logic [LIT_W-1:0]       file_data,
	input wire logic [FILE_ADDR_W-1:0] timer_zero_count_addr,
	input wire logic                   prescaler_on_timer,
	input wire decode_t                decoded,
	input wire logic                   cycle_start,
	input wire logic                   skip_next,
	input wire logic                   clear_prescaler,
	input wire logic                   clk,
	input wire logic                   rst
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Edge three of a cycle is where the skip and prescaler choices are made
	period_four_a: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
		else $error("cycle start spacing wrong");
	skip_then_idle_a: assert property (skip_next |=> cycle_start && decoded.op == op_nop)
		else $error("skipped word not idle");
	long_op_idle_a: assert property (
		cycle_start && $past(decoded.two_cycle) |-> decoded.op == op_nop)
		else $error("second cycle not idle");
	skip_needs_test_a: assert property (
		$past(cycle_start, 2) && !decoded.conditional |=> !skip_next)
		else $error("skip from plain op");
	dec_skip_zero_a: assert property (
		$past(cycle_start, 2) && decoded.op == op_dec_skip && file_data == 8'h01
		|=> skip_next)
		else $error("decrement skip missed");
	test_set_skip_a: assert property (
		$past(cycle_start, 2) && decoded.op == op_test_set
		&& file_data[decoded.bit_index] |=> skip_next)
		else $error("bit test skip missed");
	timer_prescale_a: assert property (
		$past(cycle_start, 2) && decoded.writes_file && prescaler_on_timer
		&& decoded.file_addr == timer_zero_count_addr |=> clear_prescaler)
		else $error("prescaler not cleared");
	ret_int_word_a: assert property (
		cycle_start && !$past(skip_next) && !$past(decoded.two_cycle)
		&& $past(instr_word) == 14'h0009 |-> decoded.op == op_ret_int && decoded.two_cycle)
		else $error("interrupt return not decoded");
endmodule : decoder_checker

bind instr_decoder decoder_checker chk (
	.instr_word(instr_word), .file_data(file_data),
	.timer_zero_count_addr(timer_zero_count_addr),
	.prescaler_on_timer(prescaler_on_timer), .decoded(decoded),
	.cycle_start(cycle_start), .skip_next(skip_next),
	.clear_prescaler(clear_prescaler), .clk(clk), .rst(rst)
);

// *** verif/tb_top.sv ***
module tb_top
	import decoder_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                   clk      = 1'b0;
	logic                   rst      = 1'b1;
	logic [INSTR_W-1:0]     word     = '0;
	logic [LIT_W-1:0]       fdata    = '0;
	logic [FILE_ADDR_W-1:0] io_addr  = 7'h05;
	logic [FILE_ADDR_W-1:0] tmr_addr = 7'h25;
	logic                   pre_on   = 1'b1;
	decode_t                decoded;
	logic                   cyc, skip, pins, clr_pre, sec;
	logic [1:0]             ph;
	logic                   pend_skip = 1'b0;
	logic                   pend_cp   = 1'b0;
	logic                   second    = 1'b0;
	int                     err_count = 0;
	int                     checked   = 0;
	op_t byte_op [16] = '{op_nop, op_clear, op_sub_f, op_dec_f, op_or_f, op_and_f,
		op_xor_f, op_add_f, op_move_f, op_comp_f, op_inc_f, op_dec_skip, op_rot_right,
		op_rot_left, op_swap_f, op_inc_skip};
	op_t bit_op [4] = '{op_bit_clear, op_bit_set, op_test_clear, op_test_set};
	// Directed words with the operand each one reads
	// Each skip or two-cycle word is followed by a filler that must be ignored
	logic [13:0] dir_w [$] = '{14'h0000, 14'h0060, 14'h0008, 14'h3fff, 14'h0009, 14'h3fff,
		14'h0064, 14'h0063, 14'h00a5, 14'h0185, 14'h017f, 14'h07c0, 14'h0b81, 14'h3fff, 14'h0f81,
		14'h3fff, 14'h0b81, 14'h1990, 14'h3fff, 14'h1d90, 14'h3fff, 14'h1d90, 14'h2800, 14'h3fff,
		14'h2000, 14'h3fff, 14'h3412, 14'h3fff, 14'h3012, 14'h3e55, 14'h3c55, 14'h3a55, 14'h3b55,
		14'h0068};
	logic [7:0] dir_d [$] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 8'h05, 8'hf7, 8'h00, 8'h08,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};

	// Free-running clock
	always #5 clk = ~clk;

	instr_decoder dut (
		.clk(clk), .rst(rst), .instr_word(word), .file_data(fdata),
		.first_io_port_addr(io_addr), .timer_zero_count_addr(tmr_addr),
		.prescaler_on_timer(pre_on), .decoded(decoded), .phase(ph), .cycle_start(cyc),
		.second_cycle(sec), .skip_next(skip), .read_pins(pins), .clear_prescaler(clr_pre)
	);

	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", name, exp, got);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	function automatic op_t model_op(input logic [13:0] w);
		case (w[13:12])
			2'h0: begin
				if (w[11:8] != 4'h0) return byte_op[w[11:8]];
				if (w[7]) return op_move_w_to_f;
				if (w[7:0] == 8'h08) return op_ret_sub;
				if (w[7:0] == 8'h09) return op_ret_int;
				if (w[7:0] == 8'h64) return op_wdt_clear;
				if (w[7:0] == 8'h63) return op_standby;
				return op_nop;
			end
			2'h1: return bit_op[w[11:10]];
			2'h2: return w[11] ? op_jump : op_call;
			default: begin
				if (w[11:10] == 2'h0) return op_move_lit;
				if (w[11:10] == 2'h1) return op_ret_lit;
				if (w[11:9] == 3'h6) return op_sub_lit;
				if (w[11:9] == 3'h7) return op_add_lit;
				if (w[11:8] == 4'h8) return op_or_lit;
				if (w[11:8] == 4'h9) return op_and_lit;
				if (w[11:8] == 4'ha) return op_xor_lit;
				return op_nop;
			end
		endcase
	endfunction : model_op

	// Flag order: carry, digit carry, zero, timeout, powerdown
	function automatic logic [4:0] model_flags(input op_t op);
		if (op inside {op_add_f, op_sub_f, op_add_lit, op_sub_lit}) return 5'h1c;
		if (op inside {op_or_f, op_and_f, op_xor_f, op_comp_f, op_dec_f, op_inc_f,
			op_move_f, op_clear, op_or_lit, op_and_lit, op_xor_lit}) return 5'h04;
		if (op inside {op_rot_left, op_rot_right}) return 5'h10;
		if (op inside {op_wdt_clear, op_standby}) return 5'h03;
		return 5'h00;
	endfunction : model_flags

	// Entered at edge three; a skip shows one edge later, so it is checked next call
	task automatic issue(input logic [13:0] w, input logic [7:0] fd);
		op_t  op;
		logic wf;
		logic tc;
		logic sk;
		op = second ? op_nop : model_op(w);
		wf = !second && ((w[13:12] == 2'h0 && w[7]) || op inside {op_bit_clear, op_bit_set});
		tc = op inside {op_call, op_jump, op_ret_lit, op_ret_sub, op_ret_int};
		word <= w;
		@(posedge clk);
		check("skip", 32'(skip), 32'(pend_skip));
		check("prescaler", 32'(clr_pre), 32'(pend_cp));
		check("phase end", 32'(ph), 32'(OSC_PER_INSTR - 1));
		@(posedge clk);
		check("start", 32'(cyc), 32'h1);
		check("phase start", 32'(ph), 32'h0);
		check("second", 32'(sec), 32'(second));
		check("op", 32'(decoded.op), 32'(op));
		check("flags", 32'(decoded.flags), 32'(model_flags(op)));
		check("two", 32'(decoded.two_cycle), 32'(tc));
		check("pins", 32'(pins), 32'(wf && w[6:0] == io_addr));
		if (!second && w[13:12] == 2'h1)
			check("bit", 32'({decoded.uses_file, decoded.bit_index, decoded.file_addr}),
				32'({1'b1, w[9:0]}));
		if (!second && w[13:12] == 2'h0 && w[11:9] != 3'h0)
			check("dest", 32'({decoded.uses_file, decoded.writes_w, decoded.writes_file,
				decoded.dest_file, decoded.file_addr}),
				32'({1'b1, ~w[7], w[7], w[7:0]}));
		if (!second && w[13:12] == 2'h3 && op != op_nop)
			check("literal", 32'(decoded.literal), 32'(w[7:0]));
		if (!second && w[13:12] == 2'h2)
			check("jump", 32'(decoded.jump_addr), 32'(w[10:0]));
		fdata <= fd;
		sk = (op == op_dec_skip && fd == 8'h01) || (op == op_inc_skip && fd == 8'hff)
			|| (op == op_test_clear && !fd[w[9:7]]) || (op == op_test_set && fd[w[9:7]]);
		pend_skip = sk;
		pend_cp = wf && w[6:0] == tmr_addr && pre_on;
		second = sk || tc;
		repeat (2) @(posedge clk);
	endtask : issue

	// Main sequence: align to edge three, then directed and random words
	initial begin
		logic [13:0] w;
		void'($urandom(32'h7dc8));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		do @(posedge clk); while (cyc !== 1'b1);
		repeat (2) @(posedge clk);
		foreach (dir_w[i]) issue(dir_w[i], dir_d[i]);
		$display("test directed done");
		repeat (300) begin
			w = 14'($urandom);
			tmr_addr <= $urandom_range(1) ? w[6:0] : 7'h7f;
			io_addr <= $urandom_range(1) ? w[6:0] : 7'h7e;
			pre_on <= 1'($urandom);
			issue(w, $urandom_range(1) ? 8'hff : 8'($urandom));
		end
		// The last word's skip and prescaler pulses show one edge before the next start edge
		@(posedge clk);
		check("skip", 32'(skip), 32'(pend_skip));
		check("prescaler", 32'(clr_pre), 32'(pend_cp));
		$display("test random done");
		end_sim();
	end

	// Watchdog far beyond the expected run length
	initial begin
		#(20000 * 10);
		err_count++;
		$display("mismatch watchdog expected finish seen timeout");
		end_sim();
	end
endmodule : tb_top
